// >>> logic/scs_cmd_check.sv
`timescale 1ns/1ps
`default_nettype none
module scs_cmd_check
	import scs_pkg::*;
(
	input  wire logic [7:0] code,    // pending command code
	input  wire logic [3:0] proto,   // protocol selection
	input  wire logic [7:0] state,   // current state code
	input  wire logic       sock0,   // this is socket 0
	output scs_verdict_t    verdict  // accept and state move
);
	logic tcp;
	logic ppp;

	assign tcp = proto == SCS_PROTO_TCP;
	assign ppp = sock0 && proto == SCS_PROTO_PPP;

	always_comb
	begin
		verdict = '{accept: 1'b0, new_state: 1'b0, state: state};
		case (code)
			SCS_CMD_OPEN:
			begin
				verdict.accept    = 1'b1;
				verdict.new_state = 1'b1;
				case (proto)
					SCS_PROTO_TCP:    verdict.state = SCS_ST_TCP_INIT;
					SCS_PROTO_UDP:    verdict.state = SCS_ST_DGRAM;
					SCS_PROTO_IPRAW:  verdict.state = SCS_ST_RAW_IP;
					SCS_PROTO_MACRAW: verdict.state = SCS_ST_RAW_FRAME;
					SCS_PROTO_PPP:    verdict.state = SCS_ST_PPP;
					default:          verdict.new_state = 1'b0;
				endcase
				// raw frame and session modes exist on socket 0 only
				if (!sock0 && (proto == SCS_PROTO_MACRAW || proto == SCS_PROTO_PPP))
					verdict.new_state = 1'b0;
			end
			SCS_CMD_LISTEN:
			begin
				verdict.accept    = tcp && state == SCS_ST_TCP_INIT;
				verdict.new_state = verdict.accept;
				verdict.state     = SCS_ST_TCP_WAIT;
			end
			SCS_CMD_CONNECT:
				verdict.accept = tcp && state == SCS_ST_TCP_INIT;
			SCS_CMD_DISCONNECT:
				verdict.accept = tcp && (state == SCS_ST_TCP_CONN
					|| state == SCS_ST_CLOSE_WT);
			SCS_CMD_CLOSE:
			begin
				verdict.accept    = 1'b1;
				verdict.new_state = 1'b1;
				verdict.state     = SCS_ST_RELEASED;
			end
			SCS_CMD_SEND:
				verdict.accept = state != SCS_ST_RELEASED && state != SCS_ST_TCP_INIT
					&& state != SCS_ST_TCP_WAIT;
			SCS_CMD_SEND_HW:
				verdict.accept = proto == SCS_PROTO_UDP && state == SCS_ST_DGRAM;
			SCS_CMD_KEEPALIVE:
				verdict.accept = tcp && state == SCS_ST_TCP_CONN;
			SCS_CMD_RX_DONE:
				verdict.accept = state != SCS_ST_RELEASED;
			SCS_CMD_PPP_BEGIN, SCS_CMD_PPP_END:
				verdict.accept = ppp;
			SCS_CMD_PPP_REQ, SCS_CMD_PPP_NAK, SCS_CMD_PPP_REJ:
				verdict.accept = ppp;
			default:
				verdict.accept = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// >>> logic/scs_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module scs_fifo
#(
	parameter int WIDTH = 12,
	parameter int DEPTH = 8
)
(
	input  wire logic             core_clk, // clock
	input  wire logic             reset_n,  // sync reset, active low
	input  wire logic [WIDTH-1:0] in_data,  // word to store
	input  wire logic             in_valid, // store request
	output logic                  in_ready, // room left
	output logic      [WIDTH-1:0] out_data, // oldest word
	output logic                  out_valid,// word available
	input  wire logic             out_ready // drain request
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin
		$error("scs_fifo: DEPTH must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_q;
	logic [AW:0]      rd_q;

	assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
	assign out_valid = wr_q != rd_q;
	assign out_data  = mem[rd_q[AW-1:0]];

	always_ff @(posedge core_clk)
	begin
		if (in_valid && in_ready)
			mem[wr_q[AW-1:0]] <= in_data;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			wr_q <= '0;
			rd_q <= '0;
		end
		else
		begin
			if (in_valid && in_ready)
				wr_q <= wr_q + 1'b1;
			if (out_valid && out_ready)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule
`default_nettype wire

// >>> logic/scs_pkg.sv
`default_nettype none
package scs_pkg;

	// ==========================================================
	// register map (socket 0 base, sockets step by 0x0100)
	// ==========================================================
	localparam logic [15:0] SCS_OFF_MODE   = 16'h4000;
	localparam logic [15:0] SCS_OFF_CMD    = 16'h4001;
	localparam logic [15:0] SCS_OFF_FLAGS  = 16'h4002;
	localparam logic [15:0] SCS_OFF_STATE  = 16'h4003;
	localparam logic [15:0] SCS_SOCK_STEP  = 16'h0100;
	localparam logic [7:0]  SCS_RST_CMD    = 8'h00;
	localparam logic [7:0]  SCS_RST_MODE   = 8'h00;
	localparam logic [7:0]  SCS_RST_FLAGS  = 8'h00;
	localparam logic [7:0]  SCS_RST_STATE  = 8'h00;
	localparam int          SCS_FIFO_DEPTH = 8;

	// ==========================================================
	// command codes
	// ==========================================================
	localparam logic [7:0] SCS_CMD_OPEN       = 8'h01;
	localparam logic [7:0] SCS_CMD_LISTEN     = 8'h02;
	localparam logic [7:0] SCS_CMD_CONNECT    = 8'h04;
	localparam logic [7:0] SCS_CMD_DISCONNECT = 8'h08;
	localparam logic [7:0] SCS_CMD_CLOSE      = 8'h10;
	localparam logic [7:0] SCS_CMD_SEND       = 8'h20;
	localparam logic [7:0] SCS_CMD_SEND_HW    = 8'h21;
	localparam logic [7:0] SCS_CMD_KEEPALIVE  = 8'h22;
	localparam logic [7:0] SCS_CMD_PPP_BEGIN  = 8'h23;
	localparam logic [7:0] SCS_CMD_PPP_END    = 8'h24;
	localparam logic [7:0] SCS_CMD_PPP_REQ    = 8'h25;
	localparam logic [7:0] SCS_CMD_PPP_NAK    = 8'h26;
	localparam logic [7:0] SCS_CMD_PPP_REJ    = 8'h27;
	localparam logic [7:0] SCS_CMD_RX_DONE    = 8'h40;

	// ==========================================================
	// protocol selections and state codes
	// ==========================================================
	localparam logic [3:0] SCS_PROTO_CLOSED = 4'h0;
	localparam logic [3:0] SCS_PROTO_TCP    = 4'h1;
	localparam logic [3:0] SCS_PROTO_UDP    = 4'h2;
	localparam logic [3:0] SCS_PROTO_IPRAW  = 4'h3;
	localparam logic [3:0] SCS_PROTO_MACRAW = 4'h4;
	localparam logic [3:0] SCS_PROTO_PPP    = 4'h5;
	localparam logic [7:0] SCS_ST_RELEASED  = 8'h00;
	localparam logic [7:0] SCS_ST_TCP_INIT  = 8'h13;
	localparam logic [7:0] SCS_ST_TCP_WAIT  = 8'h14;
	localparam logic [7:0] SCS_ST_TCP_CONN  = 8'h17;
	localparam logic [7:0] SCS_ST_CLOSE_WT  = 8'h1C;
	localparam logic [7:0] SCS_ST_DGRAM     = 8'h22;
	localparam logic [7:0] SCS_ST_RAW_IP    = 8'h32;
	localparam logic [7:0] SCS_ST_RAW_FRAME = 8'h42;
	localparam logic [7:0] SCS_ST_PPP       = 8'h5F;

	// ==========================================================
	// event flag bit positions
	// ==========================================================
	localparam int SCS_FL_CONNECT = 0;
	localparam int SCS_FL_FIN_RX  = 1;
	localparam int SCS_FL_DATA_RX = 2;
	localparam int SCS_FL_TIMEOUT = 3;
	localparam int SCS_FL_SENDOK  = 4;
	localparam int SCS_FL_PPP_LO  = 5;

	typedef struct packed {
		logic [7:0] code;
		logic [3:0] proto;
	} scs_action_t;

	typedef struct packed {
		logic       accept;
		logic       new_state;
		logic [7:0] state;
	} scs_verdict_t;

endpackage
`default_nettype wire

// >>> logic/scs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer
	import scs_pkg::*;
#(
	parameter int SOCK_IDX   = 0,
	parameter int FIFO_DEPTH = SCS_FIFO_DEPTH
)
(
	input  wire logic        core_clk,      // system clock, 100 MHz
	input  wire logic        reset_n,       // sync reset, active low
	input  wire logic [15:0] reg_addr,      // register address
	input  wire logic        reg_wr,        // write strobe
	input  wire logic        reg_rd,        // read strobe
	input  wire logic [7:0]  reg_wdata,     // write data
	output logic      [7:0]  reg_rdata,     // read data, registered
	output logic             reg_hit,       // address belongs here, registered
	output scs_action_t      act_data,      // action toward protocol engines
	output logic             act_valid,     // action available
	input  wire logic        act_ready,     // engines take action
	input  wire logic        ev_connected,  // handshake completed
	input  wire logic        ev_xport_to,   // transport timeout
	input  wire logic        ev_addr_to,    // address resolution timeout
	input  wire logic        ev_rst_rx,     // RST received from peer
	input  wire logic        ev_fin_rx,     // FIN received from peer
	input  wire logic        ev_finack_rx,  // FIN/ACK received
	input  wire logic        ev_data_rx,    // data packet received
	input  wire logic        ev_send_done,  // send finished
	input  wire logic [2:0]  ev_ppp,        // PPP receive, fail, next phase
	input  wire logic        ev_syn_noport, // SYN for a port with no socket
	output logic             rst_reply,     // RST answer request, pulse
	output logic             sock_int       // common interrupt bit for socket
);
	if (SOCK_IDX < 0 || SOCK_IDX > 7)
	begin
		$error("scs_sequencer: SOCK_IDX must be 0 to 7");
	end

	// ==========================================================
	// address decode
	// ==========================================================
	localparam logic [15:0] BASE = 16'(SOCK_IDX) * SCS_SOCK_STEP;

	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		hit = a == off + BASE;
	endfunction

	logic sel_mode;
	logic sel_cmd;
	logic sel_flags;
	logic sel_state;

	assign sel_mode  = hit(reg_addr, SCS_OFF_MODE);
	assign sel_cmd   = hit(reg_addr, SCS_OFF_CMD);
	assign sel_flags = hit(reg_addr, SCS_OFF_FLAGS);
	assign sel_state = hit(reg_addr, SCS_OFF_STATE);

	// ==========================================================
	// registers
	// ==========================================================
	logic [7:0]   mode_q;
	logic [7:0]   cmd_q;
	logic [7:0]   flags_q;
	logic [7:0]   flags_d;
	logic [7:0]   state_q;
	logic [7:0]   state_d;
	logic         conn_pend_q;
	logic         disc_pend_q;
	logic         keep_pend_q;
	logic         rst_reply_q;
	logic [7:0]   rdata_q;
	logic         hit_q;
	scs_verdict_t verdict;
	logic         fifo_ready;
	logic         any_event;
	logic         take;
	logic         push;
	logic         tcp_live;

	scs_cmd_check u_check
	(
		.code    (cmd_q),
		.proto   (mode_q[3:0]),
		.state   (state_q),
		.sock0   (SOCK_IDX == 0),
		.verdict (verdict)
	);

	// state events take precedence; a pending command waits while any state event is present
	assign any_event = ev_connected | ev_xport_to | ev_addr_to | ev_rst_rx
		| ev_fin_rx | ev_finack_rx;

	// a command is only taken when the action queue has room,
	// so a full queue holds the code visible in the command register
	assign take = cmd_q != SCS_RST_CMD && !any_event && fifo_ready
		&& !(reg_wr && sel_cmd);
	assign push = take && verdict.accept;

	assign tcp_live = state_q == SCS_ST_TCP_CONN || state_q == SCS_ST_CLOSE_WT;

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			mode_q <= SCS_RST_MODE;
		else if (reg_wr && sel_mode)
			mode_q <= reg_wdata;
	end

	// host may not read a zero here as done; flags and state tell that
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			cmd_q <= SCS_RST_CMD;
		else if (reg_wr && sel_cmd)
			cmd_q <= reg_wdata;
		else if (take)
			cmd_q <= SCS_RST_CMD;
	end

	// ==========================================================
	// socket state
	// ==========================================================
	always_comb
	begin
		state_d = state_q;
		if (ev_rst_rx)
			state_d = SCS_ST_RELEASED;
		else if (ev_addr_to && conn_pend_q)
			state_d = SCS_ST_RELEASED;
		else if (ev_xport_to && (state_q == SCS_ST_TCP_WAIT || conn_pend_q
			|| disc_pend_q || keep_pend_q))
			state_d = SCS_ST_RELEASED;
		else if (ev_finack_rx && disc_pend_q)
			state_d = SCS_ST_RELEASED;
		else if (ev_connected && (state_q == SCS_ST_TCP_WAIT || conn_pend_q))
			state_d = SCS_ST_TCP_CONN;
		else if (ev_fin_rx && state_q == SCS_ST_TCP_CONN)
			state_d = SCS_ST_CLOSE_WT;
		else if (take && verdict.new_state)
			state_d = verdict.state;
	end

	// an unmatched SYN is answered but never touches state_q
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			state_q <= SCS_RST_STATE;
		else
			state_q <= state_d;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			rst_reply_q <= 1'b0;
		else
			rst_reply_q <= ev_syn_noport;
	end

	assign rst_reply = rst_reply_q;

	// ==========================================================
	// outstanding TCP operations
	// ==========================================================
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			conn_pend_q <= 1'b0;
		else if (state_d != SCS_ST_TCP_INIT)
			conn_pend_q <= 1'b0;
		else if (push && cmd_q == SCS_CMD_CONNECT)
			conn_pend_q <= 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			disc_pend_q <= 1'b0;
		else if (state_d == SCS_ST_RELEASED)
			disc_pend_q <= 1'b0;
		else if (push && cmd_q == SCS_CMD_DISCONNECT)
			disc_pend_q <= 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			keep_pend_q <= 1'b0;
		else if (state_d != SCS_ST_TCP_CONN || ev_data_rx)
			keep_pend_q <= 1'b0;
		else if (push && cmd_q == SCS_CMD_KEEPALIVE)
			keep_pend_q <= 1'b1;
	end

	// ==========================================================
	// event flags: set wins over write-one-to-clear
	// ==========================================================
	always_comb
	begin
		flags_d = flags_q;
		if (reg_wr && sel_flags)
			flags_d = flags_q & ~reg_wdata;
		if (ev_connected && (state_q == SCS_ST_TCP_WAIT || conn_pend_q))
			flags_d[SCS_FL_CONNECT] = 1'b1;
		if (ev_fin_rx && tcp_live)
			flags_d[SCS_FL_FIN_RX] = 1'b1;
		if (ev_data_rx)
			flags_d[SCS_FL_DATA_RX] = 1'b1;
		if (ev_addr_to || ev_xport_to)
			flags_d[SCS_FL_TIMEOUT] = 1'b1;
		if (ev_send_done)
			flags_d[SCS_FL_SENDOK] = 1'b1;
		if (SOCK_IDX == 0 && mode_q[3:0] == SCS_PROTO_PPP)
			flags_d[SCS_FL_PPP_LO +: 3] = flags_d[SCS_FL_PPP_LO +: 3] | ev_ppp;
	end

	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
			flags_q <= SCS_RST_FLAGS;
		else
			flags_q <= flags_d;
	end

	// interrupt bit follows the flags, so clearing the last one drops it
	assign sock_int = |flags_q;

	// ==========================================================
	// action queue toward the protocol engines
	// ==========================================================
	scs_action_t act_in;

	// the engine reads the peer address, port, hardware address and
	// buffer pointers itself; only the code and protocol travel here
	assign act_in = '{code: cmd_q, proto: mode_q[3:0]};

	scs_fifo
	#(
		.WIDTH ($bits(scs_action_t)),
		.DEPTH (FIFO_DEPTH)
	)
	u_fifo
	(
		.core_clk  (core_clk),
		.reset_n   (reset_n),
		.in_data   (act_in),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.out_data  (act_data),
		.out_valid (act_valid),
		.out_ready (act_ready)
	);

	// ==========================================================
	// read path
	// ==========================================================
	always_ff @(posedge core_clk)
	begin
		if (!reset_n)
		begin
			rdata_q <= 8'h00;
			hit_q   <= 1'b0;
		end
		else if (reg_rd)
		begin
			hit_q <= sel_mode | sel_cmd | sel_flags | sel_state;
			if (sel_mode)
				rdata_q <= mode_q;
			else if (sel_cmd)
				rdata_q <= cmd_q;
			else if (sel_flags)
				rdata_q <= flags_q;
			else if (sel_state)
				rdata_q <= state_q;
			else
				rdata_q <= 8'h00;
		end
		else
			hit_q <= 1'b0;
	end

	assign reg_rdata = rdata_q;
	assign reg_hit   = hit_q;
endmodule
`default_nettype wire

// >>> testbench/scs_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module scs_engine_model
	import scs_pkg::*;
(
	input  wire logic        core_clk,  // clock
	input  wire logic        reset_n,   // reset, low
	input  wire scs_action_t act_data,  // head
	input  wire logic        act_valid, // valid
	output logic             act_ready, // ready
	output logic      [11:0] ev         // event pulses
);
	scs_action_t got[$];
	logic        stall = 1'b0;
	initial ev = 12'h000;
	// ==========================================================
	// action intake, stalls on request
	// ==========================================================
	assign act_ready = reset_n && !stall;
	always @(posedge core_clk)
		if (act_valid && act_ready)
			got.push_back(act_data);
	// peers answer as the bench commands: connect, timeouts, rst, fin
	task automatic pulse(input int idx);
		@(posedge core_clk);
		ev[idx] <= 1'b1;
		@(posedge core_clk);
		ev[idx] <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> testbench/scs_sequencer_properties.sv
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer_properties
	import scs_pkg::*;
#(
	parameter int SOCK_IDX = 0
)
(
	input wire logic        core_clk,      // clock
	input wire logic        reset_n,       // reset, low
	input wire logic [15:0] reg_addr,      // address
	input wire logic        reg_wr,        // write
	input wire logic        reg_rd,        // read
	input wire logic [7:0]  reg_wdata,     // wdata
	input wire logic [7:0]  reg_rdata,     // rdata
	input wire logic        reg_hit,       // hit
	input wire scs_action_t act_data,      // head
	input wire logic        act_valid,     // valid
	input wire logic        act_ready,     // ready
	input wire logic        ev_connected,  // event
	input wire logic        ev_xport_to,   // event
	input wire logic        ev_addr_to,    // event
	input wire logic        ev_rst_rx,     // event
	input wire logic        ev_fin_rx,     // event
	input wire logic        ev_finack_rx,  // event
	input wire logic        ev_data_rx,    // event
	input wire logic        ev_send_done,  // event
	input wire logic [2:0]  ev_ppp,        // events
	input wire logic        ev_syn_noport, // event
	input wire logic        rst_reply,     // rst pulse
	input wire logic        sock_int       // int bit
);
	localparam logic [15:0] BASE = SCS_OFF_MODE + 16'(SOCK_IDX) * SCS_SOCK_STEP;
	logic ev_set;
	logic ev_any;
	assign ev_set = ev_connected | ev_xport_to | ev_addr_to | ev_fin_rx | ev_data_rx
		| ev_send_done | (|ev_ppp);
	assign ev_any = ev_set | ev_rst_rx | ev_finack_rx | ev_syn_noport;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// ==========================================================
	// properties
	// ==========================================================
	// taking waits out events, so the quiet cycle is part of the cause
	sequence s_open;
		reg_wr && reg_addr == BASE + 16'h0001 && reg_wdata == SCS_CMD_OPEN && !act_valid
		##1 !ev_any && !reg_wr;
	endsequence
	property p_open_taken; s_open |=> act_valid && act_data.code == SCS_CMD_OPEN; endproperty
	a_open_taken: assert property (p_open_taken) else $error("open not queued");
	property p_rst_reply; ev_syn_noport |=> rst_reply; endproperty
	a_rst_reply: assert property (p_rst_reply) else $error("no rst reply");
	property p_rst_cause; rst_reply |-> $past(ev_syn_noport); endproperty
	a_rst_cause: assert property (p_rst_cause) else $error("stray rst reply");
	property p_to_flag; ev_xport_to || ev_addr_to |=> sock_int; endproperty
	a_to_flag: assert property (p_to_flag) else $error("timeout flag missing");
	property p_sendok; ev_send_done |=> sock_int; endproperty
	a_sendok: assert property (p_sendok) else $error("send flag missing");
	property p_int_fall;
		$fell(sock_int) |-> $past(reg_wr) && $past(reg_addr) == BASE + 16'h0002;
	endproperty
	a_int_fall: assert property (p_int_fall) else $error("int dropped alone");
	property p_int_rise; $rose(sock_int) |-> $past(ev_set); endproperty
	a_int_rise: assert property (p_int_rise) else $error("int rose alone");
	property p_flags_rd;
		reg_rd && reg_addr == BASE + 16'h0002 |=> reg_hit && (|reg_rdata) == $past(sock_int);
	endproperty
	a_flags_rd: assert property (p_flags_rd) else $error("flags and int differ");
	property p_hold; act_valid && !act_ready |=> act_valid && $stable(act_data); endproperty
	a_hold: assert property (p_hold) else $error("action head moved");
	property p_unmapped;
		reg_rd && (reg_addr < BASE || reg_addr > BASE + 16'h0003) |=> !reg_hit && reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
	c_open: cover property (s_open);
	c_rst: cover property (ev_syn_noport ##1 rst_reply);
	c_clear: cover property ($fell(sock_int));
endmodule
bind scs_sequencer scs_sequencer_properties #(.SOCK_IDX(SOCK_IDX)) i_props (
	.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
	.act_data(act_data), .act_valid(act_valid), .act_ready(act_ready),
	.ev_connected(ev_connected), .ev_xport_to(ev_xport_to), .ev_addr_to(ev_addr_to),
	.ev_rst_rx(ev_rst_rx), .ev_fin_rx(ev_fin_rx), .ev_finack_rx(ev_finack_rx),
	.ev_data_rx(ev_data_rx), .ev_send_done(ev_send_done), .ev_ppp(ev_ppp),
	.ev_syn_noport(ev_syn_noport), .rst_reply(rst_reply), .sock_int(sock_int));
`default_nettype wire

// >>> testbench/socket_command_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module socket_command_sequencer_tb;
	import scs_pkg::*;
	localparam logic [7:0] OPEN_ST [6] = '{8'h00, 8'h13, 8'h22, 8'h32, 8'h42, 8'h5F};
	localparam logic [7:0] BAD [10] = '{8'h02, 8'h04, 8'h08, 8'h22, 8'h23, 8'h24, 8'h25,
		8'h26, 8'h27, 8'h55};
	logic        core_clk = 1'b0;
	logic        reset_n;
	logic [15:0] reg_addr;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic        reg_hit;
	logic        last_hit;
	scs_action_t act_data;
	logic        act_valid;
	logic        act_ready;
	logic [11:0] ev;
	logic        rst_reply;
	logic        sock_int;
	int          mismatches = 0;
	int          num_checks = 0;
	int          cycles = 0;
	int          rst_seen = 0;
	always #5 core_clk = ~core_clk;
	scs_sequencer i_dut (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_hit(reg_hit), .act_data(act_data), .act_valid(act_valid),
		.act_ready(act_ready), .ev_connected(ev[0]), .ev_xport_to(ev[1]),
		.ev_addr_to(ev[2]), .ev_rst_rx(ev[3]), .ev_fin_rx(ev[4]), .ev_finack_rx(ev[5]),
		.ev_data_rx(ev[6]), .ev_send_done(ev[7]), .ev_ppp(ev[10:8]),
		.ev_syn_noport(ev[11]), .rst_reply(rst_reply), .sock_int(sock_int));
	scs_engine_model i_peer (.core_clk(core_clk), .reset_n(reset_n), .act_data(act_data),
		.act_valid(act_valid), .act_ready(act_ready), .ev(ev));
	// ==========================================================
	// bus and compare helpers
	// ==========================================================
	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
		num_checks++;
		if (g !== e)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rchk(input logic [15:0] a, input logic [7:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 last_hit = reg_hit;
		chk($sformatf("reg %h", a), e, reg_rdata);
		@(posedge core_clk);
	endtask
	task automatic achk(input logic [7:0] c, input logic [3:0] p);
		scs_action_t h;
		h = i_peer.got.size() > 0 ? i_peer.got.pop_front() : 12'hXXX;
		chk("action", {c, p}, h);
	endtask
	// fixed waits: taking and queuing both land within three edges
	task automatic cmd(input logic [7:0] c);
		wr(SCS_OFF_CMD, c);
		repeat (3) @(posedge core_clk);
	endtask
	task automatic evp(input int k);
		i_peer.pulse(k);
		repeat (2) @(posedge core_clk);
	endtask
	task automatic open(input logic [3:0] m);
		wr(SCS_OFF_MODE, {4'h0, m});
		cmd(SCS_CMD_OPEN);
		achk(SCS_CMD_OPEN, m);
	endtask
	// ==========================================================
	// scenarios
	// ==========================================================
	task automatic t_reset;
		for (int i = 0; i < 4; i++)
			rchk(SCS_OFF_MODE + 16'(i), 8'h00);
		chk("hit", 12'h001, {11'h000, last_hit});
		rchk(16'h4004, 8'h00);
		chk("hit", 12'h000, {11'h000, last_hit});
		$display("test reset done");
	endtask
	task automatic t_open;
		for (int m = 0; m < 6; m++)
		begin
			open(4'(m));
			rchk(SCS_OFF_CMD, 8'h00);
			rchk(SCS_OFF_STATE, OPEN_ST[m]);
			cmd(SCS_CMD_CLOSE);
			achk(SCS_CMD_CLOSE, 4'(m));
			rchk(SCS_OFF_STATE, SCS_ST_RELEASED);
		end
		$display("test open done");
	endtask
	task automatic t_server(input int fail);
		open(SCS_PROTO_TCP);
		cmd(SCS_CMD_LISTEN);
		achk(SCS_CMD_LISTEN, SCS_PROTO_TCP);
		rchk(SCS_OFF_STATE, SCS_ST_TCP_WAIT);
		evp(fail);
		rchk(SCS_OFF_STATE, fail ? SCS_ST_RELEASED : SCS_ST_TCP_CONN);
		rchk(SCS_OFF_FLAGS, fail ? 8'h08 : 8'h01);
		wr(SCS_OFF_FLAGS, 8'hFF);
		rchk(SCS_OFF_FLAGS, 8'h00);
		chk("int", 12'h000, {11'h000, sock_int});
		if (!fail)
		begin
			cmd(SCS_CMD_DISCONNECT);
			achk(SCS_CMD_DISCONNECT, SCS_PROTO_TCP);
			rchk(SCS_OFF_STATE, SCS_ST_TCP_CONN);
			evp(5);
			rchk(SCS_OFF_STATE, SCS_ST_RELEASED);
		end
		$display("test server done");
	endtask
	task automatic t_client(input int k);
		open(SCS_PROTO_TCP);
		cmd(SCS_CMD_CONNECT);
		achk(SCS_CMD_CONNECT, SCS_PROTO_TCP);
		rchk(SCS_OFF_STATE, SCS_ST_TCP_INIT);
		evp(k);
		rchk(SCS_OFF_STATE, k ? SCS_ST_RELEASED : SCS_ST_TCP_CONN);
		rchk(SCS_OFF_FLAGS, k == 3 ? 8'h00 : (k ? 8'h08 : 8'h01));
		if (k == 0)
		begin
			evp(11);
			rchk(SCS_OFF_STATE, SCS_ST_TCP_CONN);
			chk("rst reply", 12'h001, 12'(rst_seen));
			evp(6);
			cmd(SCS_CMD_KEEPALIVE);
			achk(SCS_CMD_KEEPALIVE, SCS_PROTO_TCP);
			evp(1);
			rchk(SCS_OFF_STATE, SCS_ST_RELEASED);
			rchk(SCS_OFF_FLAGS, 8'h0D);
			// passive close: peer FIN first, then our disconnect
			open(SCS_PROTO_TCP);
			cmd(SCS_CMD_CONNECT);
			achk(SCS_CMD_CONNECT, SCS_PROTO_TCP);
			evp(0);
			evp(4);
			rchk(SCS_OFF_STATE, SCS_ST_CLOSE_WT);
			rchk(SCS_OFF_FLAGS, 8'h0F);
			cmd(SCS_CMD_DISCONNECT);
			achk(SCS_CMD_DISCONNECT, SCS_PROTO_TCP);
			evp(5);
			rchk(SCS_OFF_STATE, SCS_ST_RELEASED);
		end
		wr(SCS_OFF_FLAGS, 8'hFF);
		$display("test client done");
	endtask
	task automatic t_udp;
		open(SCS_PROTO_UDP);
		foreach (BAD[i])
		begin
			cmd(BAD[i]);
			rchk(SCS_OFF_CMD, 8'h00);
			rchk(SCS_OFF_STATE, SCS_ST_DGRAM);
		end
		chk("queue", 12'h000, 12'(i_peer.got.size()));
		evp(8);
		rchk(SCS_OFF_FLAGS, 8'h00);
		cmd(SCS_CMD_SEND);
		achk(SCS_CMD_SEND, SCS_PROTO_UDP);
		evp(7);
		rchk(SCS_OFF_FLAGS, 8'h10);
		wr(SCS_OFF_FLAGS, 8'hFF);
		cmd(SCS_CMD_SEND_HW);
		achk(SCS_CMD_SEND_HW, SCS_PROTO_UDP);
		cmd(SCS_CMD_RX_DONE);
		achk(SCS_CMD_RX_DONE, SCS_PROTO_UDP);
		evp(3);
		rchk(SCS_OFF_STATE, SCS_ST_RELEASED);
		$display("test udp done");
	endtask
	task automatic t_ppp;
		open(SCS_PROTO_PPP);
		for (int c = 8'h23; c <= 8'h27; c++)
		begin
			cmd(8'(c));
			achk(8'(c), SCS_PROTO_PPP);
		end
		evp(8);
		rchk(SCS_OFF_FLAGS, 8'h20);
		evp(9);
		evp(10);
		rchk(SCS_OFF_FLAGS, 8'hE0);
		wr(SCS_OFF_FLAGS, 8'hFF);
		$display("test ppp done");
	endtask
	// nine opens against eight entries: the last one must wait in the register
	task automatic t_fifo;
		i_peer.stall <= 1'b1;
		wr(SCS_OFF_MODE, 8'h02);
		repeat (9) cmd(SCS_CMD_OPEN);
		rchk(SCS_OFF_CMD, SCS_CMD_OPEN);
		i_peer.stall <= 1'b0;
		repeat (12) @(posedge core_clk);
		rchk(SCS_OFF_CMD, 8'h00);
		chk("queue", 12'h009, 12'(i_peer.got.size()));
		repeat (9) achk(SCS_CMD_OPEN, SCS_PROTO_UDP);
		$display("test fifo done");
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		cycles++;
		if (rst_reply)
			rst_seen++;
		if (cycles == 20000)
		begin
			mismatches++;
			complete_run;
		end
	end
	initial
	begin
		reset_n = 1'b0;
		reg_addr = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
		repeat (3) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		t_reset;
		t_open;
		t_server(0);
		t_server(1);
		for (int k = 0; k < 4; k++)
			t_client(k);
		t_udp;
		t_ppp;
		t_fifo;
		complete_run;
	end
endmodule
`default_nettype wire
